//--- thsa_block.v
// Purpose: scratchpad, nonvolatile limits, alarm flag and power report
// Assumes: byte and read-slot strobes come from a bus engine on clk
// Notes: write bytes pass a small fifo so copy can stall the loader
`timescale 1ns/1ps
`include "thsa_regs.vh"

module thsa_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  reg             ready_q;
  wire            push;
  wire            pop;

  // ready is a flop so the top-level port has no logic behind it
  assign in_ready  = ready_q;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset; only pointers matter
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // occupancy after this edge; ready is registered from it
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // pointers wrap at depth, so depth is a power of two
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q <= 1'b1;
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count   <= next_count;
      ready_q <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule

module thsa_block #(
  parameter [7:0]  FAMILY_CODE   = 8'h5a,          // arbitrary value
  parameter [47:0] SERIAL_NUMBER = 48'h0123456789ab, // arbitrary value
  parameter [7:0]  NV_UPPER_INIT = 8'h7f,
  parameter [7:0]  NV_LOWER_INIT = 8'h80,
  parameter [1:0]  NV_RES_INIT   = `THSA_RES_RESET,
  parameter        COPY_CYCLES   = `THSA_COPY_CYCLES,
  parameter        RECALL_CYCLES = `THSA_RECALL_CYCLES,
  parameter        FIFO_DEPTH    = 4
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // command strobes from the bus engine
  input  wire        bus_reset,
  input  wire        rom_cmd_valid,
  input  wire [7:0]  rom_cmd,
  input  wire        func_cmd_valid,
  input  wire [7:0]  func_cmd,
  // write data bytes
  input  wire        wr_valid,
  output wire        wr_ready,
  input  wire [7:0]  wr_data,
  // read slots
  input  wire        rd_slot,
  output reg         rd_bit_valid,
  output reg         rd_bit,
  // conversion datapath
  output reg         conv_start,
  output reg  [1:0]  conv_resolution,
  input  wire        conv_done,
  input  wire [15:0] conv_result,
  // supply pin
  input  wire        vdd_present,
  // status
  output reg         alarm_flag,
  output reg         alarm_search_active,
  output reg         parasite_mode,
  output reg  [63:0] rom_code
);
  // one-hot modes of the function command in progress
  localparam M_IDLE   = 7'h01;
  localparam M_WRITE  = 7'h02;
  localparam M_READ   = 7'h04;
  localparam M_CONV   = 7'h08;
  localparam M_COPY   = 7'h10;
  localparam M_RECALL = 7'h20;
  localparam M_POWER  = 7'h40;

  localparam [7:0] CRC_POLY = 8'h8c;

  // reflected crc over the low nbits of a 64-bit word
  function [7:0] crc_bits;
    input [63:0] data;
    input integer nbits;
    integer i;
    reg [7:0] c;
    reg       fb;
    begin
      c = 8'h00;
      for (i = 0; i < 64; i = i + 1) begin
        if (i < nbits) begin
          fb = c[0] ^ data[i];
          c  = {1'b0, c[7:1]};
          if (fb) begin
            c = c ^ CRC_POLY;
          end
        end
      end
      crc_bits = c;
    end
  endfunction

  // identity code is fixed at build time
  localparam [63:0] ROM_CODE = {crc_bits({8'h00, SERIAL_NUMBER, FAMILY_CODE}, 56),
                                SERIAL_NUMBER, FAMILY_CODE};

  reg  [6:0]  mode;
  reg  [15:0] temperature;
  reg  [7:0]  upper_alarm_limit;
  reg  [7:0]  lower_alarm_limit;
  reg  [1:0]  res_bits;
  reg  [7:0]  nv_upper;
  reg  [7:0]  nv_lower;
  reg  [1:0]  nv_res;
  reg  [7:0]  scratchpad_checksum;
  reg         conv_busy;
  reg         copy_busy;
  reg  [31:0] copy_cnt;
  reg         recall_busy;
  reg  [31:0] recall_cnt;
  reg  [1:0]  wr_idx;
  reg  [6:0]  rd_pos;
  reg         vdd_meta;
  reg         vdd_sync;
  wire        load_valid;
  wire        load_ready;
  wire [7:0]  load_data;
  wire [7:0]  resolution_config;
  wire [63:0] sp_low;
  wire signed [7:0] conv_cmp;
  reg  [7:0]  rd_byte;

  // write bytes pass the fifo; copy or recall stalls the loader
  thsa_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (load_valid),
    .out_ready (load_ready),
    .out_data  (load_data)
  );

  assign load_ready = (mode == M_WRITE) && !copy_busy && !recall_busy;

  // configuration byte: only the two resolution bits are real
  assign resolution_config = `THSA_CFG_FIXED |
                             {1'b0, res_bits, 5'h00};

  // scratchpad bytes 0..7, lsb byte first
  assign sp_low = {`THSA_RSVD_VALUE, `THSA_RSVD_VALUE, `THSA_RSVD_VALUE,
                   resolution_config, lower_alarm_limit,
                   upper_alarm_limit, temperature};

  assign conv_cmp = conv_result[11:4];

  // byte selected by the read position
  always @* begin
    rd_byte = `THSA_RSVD_VALUE;
    case (rd_pos[6:3])
      `THSA_TEMP_LOW:  rd_byte = sp_low[7:0];
      `THSA_TEMP_HIGH: rd_byte = sp_low[15:8];
      `THSA_UPPER_LIM: rd_byte = sp_low[23:16];
      `THSA_LOWER_LIM: rd_byte = sp_low[31:24];
      `THSA_RES_CFG:   rd_byte = sp_low[39:32];
      `THSA_RSVD_A:    rd_byte = sp_low[47:40];
      `THSA_RSVD_B:    rd_byte = sp_low[55:48];
      `THSA_RSVD_C:    rd_byte = sp_low[63:56];
      `THSA_CHECKSUM:  rd_byte = scratchpad_checksum;
      default:         rd_byte = `THSA_RSVD_VALUE;
    endcase
  end

  // supply pin comes from outside, two flops before use
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vdd_meta <= 1'b1; // matches parasite_mode reset, no false report
      vdd_sync <= 1'b1;
    end else begin
      vdd_meta <= vdd_present;
      vdd_sync <= vdd_meta;
    end
  end

  // identity code and checksum, registered so outputs come from flops
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rom_code            <= ROM_CODE;
      scratchpad_checksum <= 8'h00;
      parasite_mode       <= 1'b0;
      conv_resolution     <= `THSA_RES_RESET;
    end else begin
      scratchpad_checksum <= crc_bits(sp_low, 64);
      parasite_mode       <= !vdd_sync;
      conv_resolution     <= res_bits;
    end
  end

  // function command mode; bus reset ends any transfer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= M_IDLE;
    end else if (bus_reset) begin
      mode <= M_IDLE;
    end else if (func_cmd_valid) begin
      case (func_cmd)
        `THSA_CMD_WRITE:   mode <= M_WRITE;
        `THSA_CMD_READ:    mode <= M_READ;
        `THSA_CMD_CONVERT: mode <= M_CONV;
        `THSA_CMD_COPY:    mode <= M_COPY;
        `THSA_CMD_RECALL:  mode <= M_RECALL;
        `THSA_CMD_POWER:   mode <= M_POWER;
        default:           mode <= M_IDLE;
      endcase
    end
  end

  // alarm search participation, latched per rom command
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_search_active <= 1'b0;
    end else if (bus_reset) begin
      alarm_search_active <= 1'b0;
    end else if (rom_cmd_valid) begin
      alarm_search_active <= (rom_cmd == `THSA_ROM_ALARM) && alarm_flag;
    end
  end

  // conversion: started only by command, result and alarm on done
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_start  <= 1'b0;
      conv_busy   <= 1'b0;
      temperature <= `THSA_TEMP_RESET;
      alarm_flag  <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (func_cmd_valid && func_cmd == `THSA_CMD_CONVERT && !conv_busy && !bus_reset) begin
        conv_start <= 1'b1;
        conv_busy  <= 1'b1;
      end else if (conv_done && conv_busy) begin
        conv_busy   <= 1'b0;
        temperature <= conv_result;
        // strict compare, equality is in range
        alarm_flag <= (conv_cmp > $signed(upper_alarm_limit)) ||
                      (conv_cmp < $signed(lower_alarm_limit));
      end
    end
  end

  // scratchpad limits, configuration and nonvolatile copy
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_alarm_limit <= 8'h00;
      lower_alarm_limit <= 8'h00;
      res_bits          <= `THSA_RES_RESET;
      nv_upper          <= NV_UPPER_INIT;
      nv_lower          <= NV_LOWER_INIT;
      nv_res            <= NV_RES_INIT;
      wr_idx            <= 2'd0;
      copy_busy         <= 1'b0;
      copy_cnt          <= 32'd0;
      recall_busy       <= 1'b1;
      recall_cnt        <= 32'd0;
    end else begin
      if (func_cmd_valid && func_cmd == `THSA_CMD_WRITE) begin
        wr_idx <= 2'd0;
      end else if (load_valid && load_ready) begin
        // bytes beyond the third are drained and dropped
        case (wr_idx)
          2'd0:    upper_alarm_limit <= load_data;
          2'd1:    lower_alarm_limit <= load_data;
          2'd2:    res_bits <= {load_data[`THSA_CFG_RES_HI],
                                load_data[`THSA_CFG_RES_LO]};
          default: wr_idx <= wr_idx;
        endcase
        if (wr_idx != 2'd3) begin
          wr_idx <= wr_idx + 2'd1;
        end
      end
      // copy holds for the write time, then commits
      if (func_cmd_valid && func_cmd == `THSA_CMD_COPY && !copy_busy && !bus_reset) begin
        copy_busy <= 1'b1;
        copy_cnt  <= 32'd0;
      end else if (copy_busy) begin
        if (copy_cnt == COPY_CYCLES - 1) begin
          copy_busy <= 1'b0;
          nv_upper  <= upper_alarm_limit;
          nv_lower  <= lower_alarm_limit;
          nv_res    <= res_bits;
        end else begin
          copy_cnt <= copy_cnt + 32'd1;
        end
      end
      // recall also runs once out of reset
      if (func_cmd_valid && func_cmd == `THSA_CMD_RECALL && !recall_busy && !bus_reset) begin
        recall_busy <= 1'b1;
        recall_cnt  <= 32'd0;
      end else if (recall_busy) begin
        if (recall_cnt == RECALL_CYCLES - 1) begin
          recall_busy       <= 1'b0;
          upper_alarm_limit <= nv_upper;
          lower_alarm_limit <= nv_lower;
          res_bits          <= nv_res;
        end else begin
          recall_cnt <= recall_cnt + 32'd1;
        end
      end
    end
  end

  // read slots: answer one cycle after the slot strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_bit_valid <= 1'b0;
      rd_bit       <= 1'b1;
      rd_pos       <= 7'd0;
    end else begin
      rd_bit_valid <= rd_slot;
      if (func_cmd_valid && func_cmd == `THSA_CMD_READ) begin
        rd_pos <= 7'd0;
      end else if (rd_slot) begin
        case (mode)
          M_READ: begin
            rd_bit <= rd_byte[rd_pos[2:0]];
            if (rd_pos != 7'd72) begin
              rd_pos <= rd_pos + 7'd1;
            end
          end
          M_RECALL: rd_bit <= !recall_busy;
          M_CONV:   rd_bit <= !conv_busy;
          M_COPY:   rd_bit <= !copy_busy;
          M_POWER:  rd_bit <= vdd_sync;
          default:  rd_bit <= 1'b1;
        endcase
      end
    end
  end
endmodule

//--- thsa_regs.vh
// Purpose: constants of the thermometer scratchpad and alarm block
// Assumes: 125 MHz clk; bit time slots are handled by a separate bus engine
// Notes: scratchpad byte indices, command codes, reset values, timing
//
// Summary of operation
// - after each conversion compare temperature bits 11..4, signed, with both limits
// - set alarm flag when value above upper limit or below lower limit
// - alarm flag recomputed at every conversion, so it clears when back in range
// - alarm search: only devices with alarm flag set take part
// - limits held as signed two's complement bytes, sign in bit 7
// - upper and lower limits are scratchpad bytes 2 and 3, nonvolatile backed
// - power query read slot: parasite device drives low, supplied device stays high
// - identity code: family low byte, 48-bit serial, crc of low 56 bits on top
// - bytes 0 and 1 show temperature low and high byte, read-only
// - byte 4 shows the configuration byte
// - bytes 5 to 7 reserved, unwritable, read as all ones
// - byte 8 is read-only crc of bytes 0..7, kept current
// - write command loads bytes 2, 3, 4 in order, lsb of byte 2 first
// - read command shifts scratchpad out lsb of byte 0 first, upward
// - copy command stores limits and configuration into nonvolatile storage
// - at power-up nonvolatile values reload into bytes 2, 3, 4
// - recall reloads nonvolatile values; read slots give 0 while busy, 1 when done
// - temperature is 16-bit sign-extended two's complement in sixteenths
// - temperature register holds plus 85 degrees after power-on
// - conversion starts only on the convert command
// - two resolution bits select 9 to 12 bits, default 12
`ifndef THSA_REGS_VH
`define THSA_REGS_VH

// scratchpad byte indices
`define THSA_TEMP_LOW   4'h0
`define THSA_TEMP_HIGH  4'h1
`define THSA_UPPER_LIM  4'h2
`define THSA_LOWER_LIM  4'h3
`define THSA_RES_CFG    4'h4
`define THSA_RSVD_A     4'h5
`define THSA_RSVD_B     4'h6
`define THSA_RSVD_C     4'h7
`define THSA_CHECKSUM   4'h8

// function and rom command codes
`define THSA_CMD_CONVERT 8'h44
`define THSA_CMD_WRITE   8'h4e
`define THSA_CMD_READ    8'hbe
`define THSA_CMD_COPY    8'h48
`define THSA_CMD_RECALL  8'hb8
`define THSA_CMD_POWER   8'hb4
`define THSA_ROM_ALARM   8'hec

// configuration byte layout
`define THSA_CFG_RES_LO  5
`define THSA_CFG_RES_HI  6
`define THSA_CFG_FIXED   8'h1f
`define THSA_RSVD_VALUE  8'hff

// reset values
`define THSA_TEMP_RESET  16'h0550
`define THSA_RES_RESET   2'h3

// timing
`define THSA_CLK_MHZ      125
`define THSA_COPY_TIME_MS 10
`define THSA_COPY_CYCLES  (`THSA_COPY_TIME_MS * 1000 * `THSA_CLK_MHZ)
`define THSA_RECALL_CYCLES 16

`endif

//--- thsa_block_monitor.sv
// Purpose: port-level checker of thsa_block timing and status relations
// Assumes: one clk domain, reset_n asynchronous active low
// Notes: alarm limits are internal, so flag values are judged in the bench
`timescale 1ns/1ps
module thsa_block_monitor (
  // clock and reset
  input wire       clk,
  input wire       reset_n,
  // command strobes
  input wire       bus_reset,
  input wire       rom_cmd_valid,
  input wire [7:0] rom_cmd,
  input wire       func_cmd_valid,
  input wire [7:0] func_cmd,
  // slots and conversion
  input wire       rd_slot,
  input wire       rd_bit_valid,
  input wire       conv_start,
  input wire       conv_done,
  // supply and status
  input wire       vdd_present,
  input wire       alarm_flag,
  input wire       alarm_search_active,
  input wire       parasite_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // conversion request only follows a convert command, one cycle long
  chk_conv_on_cmd: assert property (
    conv_start |-> $past(func_cmd_valid && func_cmd == 8'h44))
    else $error("conv_start without convert command");
  chk_conv_one_cycle: assert property (
    conv_start |=> !conv_start)
    else $error("conv_start longer than one cycle");
  // every read slot answered exactly one cycle later, never unasked
  chk_slot_answer: assert property (
    rd_slot |=> rd_bit_valid)
    else $error("read slot not answered");
  chk_slot_cause: assert property (
    rd_bit_valid |-> $past(rd_slot))
    else $error("read answer without slot");
  // flag moves only on a finished conversion
  chk_alarm_on_conv: assert property (
    $changed(alarm_flag) |-> $past(conv_done))
    else $error("alarm flag changed without conversion");
  // alarm search takes part only with the flag set
  chk_search_latch: assert property (
    rom_cmd_valid && rom_cmd == 8'hec && !bus_reset |=> alarm_search_active == $past(alarm_flag))
    else $error("alarm search participation wrong");
  chk_search_clear: assert property (
    bus_reset |=> !alarm_search_active)
    else $error("search participation kept over bus reset");
  // supply report follows the pin after the synchroniser settles
  chk_power_low: assert property (
    (!vdd_present) [*5] |-> parasite_mode)
    else $error("parasite mode not reported");
  chk_power_high: assert property (
    vdd_present [*5] |-> !parasite_mode)
    else $error("supplied mode not reported");
endmodule

bind thsa_block thsa_block_monitor mon (
  .clk(clk), .reset_n(reset_n), .bus_reset(bus_reset),
  .rom_cmd_valid(rom_cmd_valid), .rom_cmd(rom_cmd),
  .func_cmd_valid(func_cmd_valid), .func_cmd(func_cmd),
  .rd_slot(rd_slot), .rd_bit_valid(rd_bit_valid), .conv_start(conv_start),
  .conv_done(conv_done), .vdd_present(vdd_present), .alarm_flag(alarm_flag),
  .alarm_search_active(alarm_search_active), .parasite_mode(parasite_mode));

//--- thsa_master_model.sv
// Purpose: bus master and bus engine stand-in for thsa_block
// Assumes: requests change just after a rising clk edge, held one cycle, write bytes until taken or out of tries
// Notes: released buses show the inverse of their last value
`timescale 1ns/1ps
module thsa_master_model (
  // clock
  input  wire       clk,
  // command strobes
  output reg        bus_reset      = 1'b0,
  output reg        rom_cmd_valid  = 1'b0,
  output reg  [7:0] rom_cmd        = 8'h00,
  output reg        func_cmd_valid = 1'b0,
  output reg  [7:0] func_cmd       = 8'h00,
  // write bytes
  output reg        wr_valid       = 1'b0,
  input  wire       wr_ready,
  output reg  [7:0] wr_data        = 8'h00,
  // read slots
  output reg        rd_slot        = 1'b0,
  input  wire       rd_bit
);
  // reset pulse then rom command, as every transaction opens
  task rom(input [7:0] c);
    begin
      @(posedge clk) bus_reset <= 1'b1;
      @(posedge clk);
      bus_reset     <= 1'b0;
      rom_cmd_valid <= 1'b1;
      rom_cmd       <= c;
      @(posedge clk);
      rom_cmd_valid <= 1'b0;
      rom_cmd       <= ~c;
    end
  endtask
  // one function command byte
  task func(input [7:0] c);
    begin
      @(posedge clk);
      func_cmd_valid <= 1'b1;
      func_cmd       <= c;
      @(posedge clk);
      func_cmd_valid <= 1'b0;
      func_cmd       <= ~c;
    end
  endtask
  // data byte offered for at most tries edges, bytes go out in order
  task wr(input [7:0] d, input integer tries, output acc);
    integer i;
    begin
      acc = 1'b0;
      @(posedge clk);
      wr_valid <= 1'b1;
      wr_data  <= d;
      for (i = 0; i < tries && !acc; i = i + 1) begin
        @(posedge clk);
        acc = wr_ready;
      end
      wr_valid <= 1'b0;
      wr_data  <= ~d;
    end
  endtask
  // read slot, answer taken once it has landed
  task slot(output b);
    begin
      @(posedge clk) rd_slot <= 1'b1;
      @(posedge clk) rd_slot <= 1'b0;
      @(posedge clk) #1 b = rd_bit;
    end
  endtask
endmodule

//--- tb_top.sv
// Purpose: self-checking bench of thsa_block
// Assumes: 125 MHz clk, copy and recall counts shortened
// Notes: the bench plays the conversion datapath itself
`timescale 1ns/1ps
`include "thsa_regs.vh"
module tb_top;
  localparam [7:0]  FAM  = 8'h3c;           // arbitrary value
  localparam [47:0] SER  = 48'h0a1b2c3d4e5f; // arbitrary value
  localparam        COPY = 40;
  // wiring and bench state
  reg         clk = 1'b0;
  reg         reset_n = 1'b0;
  reg         conv_done = 1'b0;
  reg  [15:0] conv_result = 16'h0000;
  reg         vdd_present = 1'b1;
  wire        bus_reset, rom_cmd_valid, func_cmd_valid, wr_valid, wr_ready, rd_slot, rd_bit;
  wire        conv_start, alarm_flag, alarm_search_active, parasite_mode;
  wire [7:0]  rom_cmd, func_cmd, wr_data;
  wire [1:0]  conv_resolution;
  wire [63:0] rom_code;
  integer     fails = 0, num_checks = 0, seed = 84971, cycles = 0, i, n;
  reg         b, acc;
  reg  [7:0]  up, lo, v;
  reg  [15:0] cur;
  reg  [31:0] r;
  reg  [71:0] got;

  thsa_master_model m (.clk(clk), .bus_reset(bus_reset), .rom_cmd_valid(rom_cmd_valid),
    .rom_cmd(rom_cmd), .func_cmd_valid(func_cmd_valid), .func_cmd(func_cmd),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_slot(rd_slot),
    .rd_bit(rd_bit));
  thsa_block #(.FAMILY_CODE(FAM), .SERIAL_NUMBER(SER), .COPY_CYCLES(COPY),
    .RECALL_CYCLES(8)) uut (.clk(clk), .reset_n(reset_n), .bus_reset(bus_reset),
    .rom_cmd_valid(rom_cmd_valid), .rom_cmd(rom_cmd), .func_cmd_valid(func_cmd_valid),
    .func_cmd(func_cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_slot(rd_slot), .rd_bit_valid(), .rd_bit(rd_bit), .conv_start(conv_start),
    .conv_resolution(conv_resolution), .conv_done(conv_done), .conv_result(conv_result),
    .vdd_present(vdd_present), .alarm_flag(alarm_flag),
    .alarm_search_active(alarm_search_active), .parasite_mode(parasite_mode),
    .rom_code(rom_code));

  // lsb-first crc, x8+x5+x4+1 reflected
  function [7:0] crc8(input [63:0] d, input integer nb);
    integer k;
    begin
      crc8 = 8'h00;
      for (k = 0; k < nb; k = k + 1)
        crc8 = (crc8 >> 1) ^ ((crc8[0] ^ d[k]) ? 8'h8c : 8'h00);
    end
  endfunction
  // whole scratchpad image, reserved bytes all ones
  function [71:0] pad(input [15:0] tp, input [7:0] u, input [7:0] l, input [1:0] rs);
    reg [63:0] e;
    begin
      e = {24'hffffff, 1'b0, rs, 5'h1f, l, u, tp};
      pad = {crc8(e, 64), e};
    end
  endfunction
  // strict signed compare of bits 11..4 against both limits
  function al(input [15:0] tp, input [7:0] u, input [7:0] l);
    al = $signed(tp[11:4]) > $signed(u) || $signed(tp[11:4]) < $signed(l);
  endfunction

  task check(input [8*12-1:0] name, input [71:0] seen, input [71:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      if (fails == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task read_pad(input [71:0] exp);
    integer k;
    begin
      m.func(`THSA_CMD_READ);
      for (k = 0; k < 72; k = k + 1) begin
        m.slot(b);
        got[k] = b;
      end
      check("scratchpad", got, exp);
    end
  endtask
  task write3(input [7:0] u, input [7:0] l, input [7:0] c);
    begin
      m.func(`THSA_CMD_WRITE);
      m.wr(u, 4, acc);
      m.wr(l, 4, acc);
      m.wr(c, 4, acc);
      repeat (4) @(posedge clk);
    end
  endtask
  // datapath stand-in: status slot reads busy, then the result lands
  task convert(input [15:0] tp);
    begin
      m.func(`THSA_CMD_CONVERT);
      for (n = 0; conv_start !== 1'b1 && n < 8; n = n + 1)
        @(posedge clk);
      check("conv_start", n < 8, 1);
      m.slot(b);
      check("conv_busy", b, 0);
      @(posedge clk);
      conv_done   <= 1'b1;
      conv_result <= tp;
      @(posedge clk);
      conv_done <= 1'b0;
      @(posedge clk) #1;
      m.slot(b);
      check("conv_ready", b, 1);
    end
  endtask

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      finish_test;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge clk);
    read_pad(pad(16'h0550, 8'h7f, 8'h80, 2'b11));
    check("rom_code", rom_code, {crc8({SER, FAM}, 56), SER, FAM});
    // supply query with the pin low then high
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk) vdd_present <= i[0];
      repeat (6) @(posedge clk);
      m.rom(8'hcc);
      m.func(`THSA_CMD_POWER);
      m.slot(b);
      check("power_slot", b, i[0]);
      check("parasite", parasite_mode, !i[0]);
    end
    // random limits and configuration written and read back
    cur = 16'h0550;
    for (i = 0; i < 3; i = i + 1) begin
      r = $random(seed);
      write3(r[7:0], r[15:8], r[23:16]);
      read_pad(pad(cur, r[7:0], r[15:8], r[22:21]));
      check("resolution", conv_resolution, r[22:21]);
    end
    // limit corners first, then random readings; alarm search checked after each
    up = 8'h19;
    lo = 8'hf6;
    write3(up, lo, 8'h00);
    for (i = 0; i < 12; i = i + 1) begin
      r = $random(seed);
      v = r[11:4];
      case (i)
        0: v = 8'h1a;
        1: v = 8'h19;
        2: v = 8'hf5;
        3: v = 8'hf6;
      endcase
      cur = {{4{v[7]}}, v, r[3:0]};
      convert(cur);
      check("alarm", alarm_flag, al(cur, up, lo));
      m.rom(`THSA_ROM_ALARM);
      #1 check("search", alarm_search_active, al(cur, up, lo));
    end
    read_pad(pad(cur, up, lo, 2'b00));
    // supplied device: bytes sent during the copy wait in the fifo
    m.func(`THSA_CMD_COPY);
    m.slot(b);
    check("copy_busy", b, 0);
    m.func(`THSA_CMD_WRITE);
    n = 0;
    for (i = 0; i < 5; i = i + 1) begin
      m.wr(8'h20 + i[7:0], 2, acc);
      n = n + acc;
    end
    check("fifo_fill", n, 4);
    check("wr_ready", wr_ready, 0);
    repeat (COPY + 10) @(posedge clk);
    read_pad(pad(cur, 8'h20, 8'h21, 2'b01));
    // recall reports busy, then done, and restores the copied bytes
    m.func(`THSA_CMD_RECALL);
    m.slot(b);
    check("recall_busy", b, 0);
    for (n = 0; b !== 1'b1 && n < 20; n = n + 1)
      m.slot(b);
    check("recall_done", b, 1);
    read_pad(pad(cur, up, lo, 2'b00));
    finish_test;
  end
endmodule
